// ---- rtl/dsfm_regs.svh ----
// Constants of the drive state and fault manager: bit positions, codes and reset values.
// Function
// [RULE1] Running state is reached only through the drive-profile command sequence.
// [RULE2] Init state rejects every parameter write and runs no function.
// [RULE3] No-fault state accepts parameter writes.
// [RULE4] Running energizes the motor; it moves only with nonzero speed reference.
// [RULE5] Running, quick-stop, fault halt accept only run-changeable parameter writes.
// [RULE6] Quick stop command enters quick-stop state and performs the stop.
// [RULE7] A fault enters the fault halt state and performs the stop.
// [RULE8] After fault stop, fault state inhibits functions but accepts parameter writes.
// [RULE9] Faults sort into levels 1 to 3; level 1 resettable or not.
// [RULE10] A valid reset request stops display of resettable faults and warnings.
// [RULE11] Writing one to the fault reset parameter requests a reset.
// [RULE12] Rising edge of control word bit 7 requests a reset; level does not.
// [RULE13] Level 1 and 2 resettable faults clear only with servo-on dropped.
// [RULE14] Level 3 warnings clear by themselves when their source disappears.
// [RULE15] Fault reset parameter powers up zero and self-returns to zero.
// [RULE16] Fault reset parameter writes accepted only while stopped, effective immediately.
// [RULE17] System, configuration, timeout and program faults are non-resettable level 1.
// [RULE18] Parameter timeouts and nonvolatile check faults are resettable level 2.
// [RULE19] The host control word is a 16-bit object.
// [RULE20] Most severe active level is reported first; lower ones stay latched.
`ifndef DSFM_REGS_SVH
`define DSFM_REGS_SVH

`define DSFM_CW_W 16
`define DSFM_CW_SWITCH_ON 0
`define DSFM_CW_EN_VOLT 1
`define DSFM_CW_QSTOP_N 2
`define DSFM_CW_EN_OP 3
`define DSFM_CW_FLT_RST 7
`define DSFM_FRP_W 16
`define DSFM_FRP_NOP 16'h0000
`define DSFM_FRP_RESET 16'h0001
`define DSFM_L1NR_W 8
`define DSFM_L1R_W 4
`define DSFM_L2_W 4
`define DSFM_WARN_W 4
`define DSFM_LVL_NONE 2'h0
`define DSFM_LVL_1 2'h1
`define DSFM_LVL_2 2'h2
`define DSFM_LVL_3 2'h3

`endif

// ---- rtl/dsfm_pkg.sv ----
// Types of the drive state and fault manager.
package dsfm_pkg;

  typedef enum logic [2:0] {
    DSFM_INIT,
    DSFM_NO_FAULT,
    DSFM_READY,
    DSFM_WAIT_ON,
    DSFM_RUNNING,
    DSFM_QUICK_STOP,
    DSFM_FAULT_HALT,
    DSFM_FAULT
  } dsfm_state_t;

endpackage

// ---- rtl/dsfm_top.sv ----
// Drive-profile state machine, parameter write gating and fault classification.
`timescale 1ns/1ps
`include "dsfm_regs.svh"

module dsfm_top #(
  parameter int L1NR_W = `DSFM_L1NR_W,
  parameter int L1R_W = `DSFM_L1R_W,
  parameter int L2_W = `DSFM_L2_W,
  parameter int WARN_W = `DSFM_WARN_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic self_check_done,
  input wire logic host_cw_valid,
  input wire logic [`DSFM_CW_W-1:0] host_control_word,
  input wire logic param_wr_req,
  input wire logic param_wr_run_ok,
  input wire logic param_wr_is_frp,
  input wire logic [`DSFM_FRP_W-1:0] param_wr_data,
  input wire logic speed_ref_nz,
  input wire logic stop_done,
  input wire logic [L1NR_W-1:0] l1nr_src,
  input wire logic [L1R_W-1:0] l1r_src,
  input wire logic [L2_W-1:0] l2_src,
  input wire logic [WARN_W-1:0] warn_src,
  output logic [2:0] drive_state_r,
  output logic param_wr_ack_r,
  output logic param_wr_nak_r,
  output logic motor_energize_r,
  output logic motor_move_r,
  output logic stop_active_r,
  output logic func_inhibit_r,
  output logic servo_on_r,
  output logic [`DSFM_FRP_W-1:0] fault_reset_param_r,
  output logic reset_done_r,
  output logic [L1NR_W-1:0] l1nr_latch_r,
  output logic [L1R_W-1:0] l1r_latch_r,
  output logic [L2_W-1:0] l2_latch_r,
  output logic [WARN_W-1:0] warn_disp_r,
  output logic [1:0] fault_level_r
);

  dsfm_pkg::dsfm_state_t state_r;
  dsfm_pkg::dsfm_state_t state_nxt;
  logic cw_rst_bit_r;
  logic [WARN_W-1:0] warn_src_d_r;

  // [RULE19] 16-bit control word
  // Control word decode, standard drive-profile command patterns.
  wire logic cw_on = host_control_word[`DSFM_CW_SWITCH_ON];
  wire logic cw_ev = host_control_word[`DSFM_CW_EN_VOLT];
  wire logic cw_qs_n = host_control_word[`DSFM_CW_QSTOP_N];
  wire logic cw_eo = host_control_word[`DSFM_CW_EN_OP];
  wire logic cw_rb = host_control_word[`DSFM_CW_FLT_RST];
  wire logic cmd_shutdown = host_cw_valid && cw_ev && cw_qs_n && !cw_on;
  wire logic cmd_switch_on = host_cw_valid && cw_ev && cw_qs_n && cw_on && !cw_eo;
  wire logic cmd_enable = host_cw_valid && cw_ev && cw_qs_n && cw_on && cw_eo;
  wire logic cmd_dis_volt = host_cw_valid && !cw_ev;
  wire logic cmd_qstop = host_cw_valid && cw_ev && !cw_qs_n;

  // [RULE12] Edge detect reset
  wire logic cw_rst_edge = host_cw_valid && cw_rb && !cw_rst_bit_r;

  wire logic st_init = (state_r == dsfm_pkg::DSFM_INIT);
  wire logic st_run = (state_r == dsfm_pkg::DSFM_RUNNING);
  wire logic st_qs = (state_r == dsfm_pkg::DSFM_QUICK_STOP);
  wire logic st_halt = (state_r == dsfm_pkg::DSFM_FAULT_HALT);
  wire logic st_moving = st_run || st_qs || st_halt;

  // [RULE16] Stopped-only acceptance
  wire logic frp_write = param_wr_req && param_wr_is_frp && !st_init && !st_moving;
  // [RULE11] Write of one
  wire logic frp_reset = frp_write && (param_wr_data == `DSFM_FRP_RESET);
  wire logic frp_bad = frp_write && (param_wr_data != `DSFM_FRP_RESET) &&
                       (param_wr_data != `DSFM_FRP_NOP);
  wire logic rst_req = cw_rst_edge || frp_reset;

  // [RULE13] Servo-on blocks clearing
  wire logic rst_l12 = rst_req && !servo_on_r;

  // [RULE2] Init rejects all
  wire logic wr_in_init = st_init;
  // [RULE5] Running-type states
  wire logic wr_run_ok = !st_moving || param_wr_run_ok;
  // [RULE3] Stationary states accept
  wire logic wr_ok = !wr_in_init && wr_run_ok && !frp_bad &&
                     (!param_wr_is_frp || frp_write);

  // [RULE9] Level classification
  wire logic any_l1nr = |l1nr_latch_r;
  wire logic any_l1r = |l1r_latch_r;
  wire logic any_l2 = |l2_latch_r;
  wire logic any_warn = |warn_disp_r;
  wire logic any_fault = any_l1nr || any_l1r || any_l2;

  // [RULE20] Most severe first
  wire logic [1:0] level_nxt = (any_l1nr || any_l1r) ? `DSFM_LVL_1 :
                               any_l2 ? `DSFM_LVL_2 :
                               any_warn ? `DSFM_LVL_3 : `DSFM_LVL_NONE;

  // [RULE17] Non-resettable latch
  wire logic [L1NR_W-1:0] l1nr_nxt = l1nr_latch_r | l1nr_src;
  // [RULE10] Resettable clears, new events win
  wire logic [L1R_W-1:0] l1r_nxt = (rst_l12 ? '0 : l1r_latch_r) | l1r_src;
  // [RULE18] Level two latch
  wire logic [L2_W-1:0] l2_nxt = (rst_l12 ? '0 : l2_latch_r) | l2_src;

  logic [WARN_W-1:0] warn_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < WARN_W; gi++) begin : g_warn
      // [RULE14] Auto-clear warnings
      assign warn_nxt[gi] = warn_src[gi] &&
                            ((warn_src[gi] && !warn_src_d_r[gi]) ||
                             (warn_disp_r[gi] && !rst_req));
    end
  endgenerate

  // [RULE1] Profile transitions
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      dsfm_pkg::DSFM_INIT: begin
        if (self_check_done) begin
          state_nxt = dsfm_pkg::DSFM_NO_FAULT;
        end
      end
      dsfm_pkg::DSFM_NO_FAULT: begin
        if (cmd_shutdown) begin
          state_nxt = dsfm_pkg::DSFM_READY;
        end
      end
      dsfm_pkg::DSFM_READY: begin
        if (cmd_switch_on) begin
          state_nxt = dsfm_pkg::DSFM_WAIT_ON;
        end else if (cmd_dis_volt || cmd_qstop) begin
          state_nxt = dsfm_pkg::DSFM_NO_FAULT;
        end
      end
      dsfm_pkg::DSFM_WAIT_ON: begin
        if (cmd_enable) begin
          state_nxt = dsfm_pkg::DSFM_RUNNING;
        end else if (cmd_shutdown) begin
          state_nxt = dsfm_pkg::DSFM_READY;
        end else if (cmd_dis_volt || cmd_qstop) begin
          state_nxt = dsfm_pkg::DSFM_NO_FAULT;
        end
      end
      dsfm_pkg::DSFM_RUNNING: begin
        // [RULE6] Quick stop entry
        if (cmd_qstop) begin
          state_nxt = dsfm_pkg::DSFM_QUICK_STOP;
        end else if (cmd_switch_on) begin
          state_nxt = dsfm_pkg::DSFM_WAIT_ON;
        end else if (cmd_shutdown) begin
          state_nxt = dsfm_pkg::DSFM_READY;
        end else if (cmd_dis_volt) begin
          state_nxt = dsfm_pkg::DSFM_NO_FAULT;
        end
      end
      dsfm_pkg::DSFM_QUICK_STOP: begin
        if (stop_done || cmd_dis_volt) begin
          state_nxt = dsfm_pkg::DSFM_NO_FAULT;
        end
      end
      dsfm_pkg::DSFM_FAULT_HALT: begin
        // [RULE8] Stop done to fault
        if (stop_done) begin
          state_nxt = dsfm_pkg::DSFM_FAULT;
        end
      end
      dsfm_pkg::DSFM_FAULT: begin
        if (!any_fault) begin
          state_nxt = dsfm_pkg::DSFM_NO_FAULT;
        end
      end
    endcase
    // [RULE7] Fault forces halt
    // The halt state is left alone so that stop_done can move it on to the fault state.
    if (any_fault && !st_init && !st_halt && state_r != dsfm_pkg::DSFM_FAULT) begin
      state_nxt = dsfm_pkg::DSFM_FAULT_HALT;
    end
  end

  wire logic run_nxt = (state_nxt == dsfm_pkg::DSFM_RUNNING);
  wire logic stop_nxt = (state_nxt == dsfm_pkg::DSFM_QUICK_STOP) ||
                        (state_nxt == dsfm_pkg::DSFM_FAULT_HALT);
  wire logic inhibit_nxt = (state_nxt == dsfm_pkg::DSFM_INIT) ||
                           (state_nxt == dsfm_pkg::DSFM_FAULT);
  wire logic energize_nxt = run_nxt || stop_nxt;
  wire logic move_nxt = run_nxt && speed_ref_nz;
  wire logic servo_pattern = cw_ev && cw_qs_n && cw_on && cw_eo;
  wire logic [`DSFM_FRP_W-1:0] frp_nxt = frp_reset ? `DSFM_FRP_RESET : `DSFM_FRP_NOP;
  wire logic ack_nxt = param_wr_req && wr_ok;
  wire logic nak_nxt = param_wr_req && !wr_ok;

  // The port copy of the state is registered beside state_r so it comes from a flip-flop.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= dsfm_pkg::DSFM_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_state_r <= 3'h0;
    end else begin
      drive_state_r <= state_nxt;
    end
  end

  // Both control word registers update only on a valid word, so edges span words.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cw_rst_bit_r <= 1'b0;
    end else if (host_cw_valid) begin
      cw_rst_bit_r <= cw_rb;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      servo_on_r <= 1'b0;
    end else if (host_cw_valid) begin
      servo_on_r <= servo_pattern;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      param_wr_ack_r <= 1'b0;
    end else begin
      param_wr_ack_r <= ack_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      param_wr_nak_r <= 1'b0;
    end else begin
      param_wr_nak_r <= nak_nxt;
    end
  end

  // [RULE15] Self-returning parameter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_reset_param_r <= `DSFM_FRP_NOP;
    end else begin
      fault_reset_param_r <= frp_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_done_r <= 1'b0;
    end else begin
      reset_done_r <= rst_req;
    end
  end

  // [RULE4] Energize and move
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_energize_r <= 1'b0;
    end else begin
      motor_energize_r <= energize_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_move_r <= 1'b0;
    end else begin
      motor_move_r <= move_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_active_r <= 1'b0;
    end else begin
      stop_active_r <= stop_nxt;
    end
  end

  // Functions stay inhibited through reset, as in the init state.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      func_inhibit_r <= 1'b1;
    end else begin
      func_inhibit_r <= inhibit_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      l1nr_latch_r <= '0;
    end else begin
      l1nr_latch_r <= l1nr_nxt;
    end
  end

  // Latches take their next values, in which a new event outweighs a clear.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      l1r_latch_r <= '0;
    end else begin
      l1r_latch_r <= l1r_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      l2_latch_r <= '0;
    end else begin
      l2_latch_r <= l2_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      warn_disp_r <= '0;
    end else begin
      warn_disp_r <= warn_nxt;
    end
  end

  // The delayed warning sources find the rising edge that shows a warning.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      warn_src_d_r <= '0;
    end else begin
      warn_src_d_r <= warn_src;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_level_r <= `DSFM_LVL_NONE;
    end else begin
      fault_level_r <= level_nxt;
    end
  end

endmodule

// ---- bench/dsfm_chk.sv ----
// Concurrent checks on the ports of the drive state and fault manager.
`timescale 1ns/1ps
module dsfm_chk #(
  parameter int L1NR_W = 8,
  parameter int L1R_W = 4,
  parameter int L2_W = 4,
  parameter int WARN_W = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic param_wr_req,
  input wire logic param_wr_run_ok,
  input wire logic speed_ref_nz,
  input wire logic stop_done,
  input wire logic [WARN_W-1:0] warn_src,
  input wire logic [2:0] drive_state_r,
  input wire logic param_wr_nak_r,
  input wire logic motor_energize_r,
  input wire logic motor_move_r,
  input wire logic servo_on_r,
  input wire logic [15:0] fault_reset_param_r,
  input wire logic [L1NR_W-1:0] l1nr_latch_r,
  input wire logic [L1R_W-1:0] l1r_latch_r,
  input wire logic [L2_W-1:0] l2_latch_r,
  input wire logic [WARN_W-1:0] warn_disp_r,
  input wire logic [1:0] fault_level_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  init_nak_a: assert property (
    param_wr_req && drive_state_r == 3'h0 |=> param_wr_nak_r) else $error("write taken in init");
  run_gate_a: assert property (
    param_wr_req && !param_wr_run_ok && drive_state_r inside {3'h4, 3'h5, 3'h6}
    |=> param_wr_nak_r) else $error("run write gate open");
  frp_return_a: assert property (
    fault_reset_param_r != 16'h0000 && !param_wr_req |=> fault_reset_param_r == 16'h0000)
    else $error("fault reset value stuck");
  motor_move_a: assert property (
    motor_move_r |-> motor_energize_r && $past(speed_ref_nz)) else $error("motor moved wrongly");
  hard_hold_a: assert property (
    l1nr_latch_r != 0 |=> (l1nr_latch_r & $past(l1nr_latch_r)) == $past(l1nr_latch_r))
    else $error("hard fault cleared");
  servo_hold_a: assert property (
    {l1r_latch_r, l2_latch_r} != 0 && servo_on_r |=>
    ({l1r_latch_r, l2_latch_r} & $past({l1r_latch_r, l2_latch_r})) ==
    $past({l1r_latch_r, l2_latch_r})) else $error("fault cleared with servo on");
  fault_halt_a: assert property (
    {l1nr_latch_r, l1r_latch_r, l2_latch_r} != 0 && !(drive_state_r inside {3'h0, 3'h6, 3'h7})
    |=> drive_state_r == 3'h6) else $error("fault did not halt");
  level_one_a: assert property (
    {l1nr_latch_r, l1r_latch_r} != 0 |=> fault_level_r == 2'h1) else $error("level not one");
  warn_clear_a: assert property (
    warn_src == 0 |=> warn_disp_r == 0) else $error("warning kept");
  halt_done_a: assert property (
    drive_state_r == 3'h6 && stop_done |=> drive_state_r == 3'h7) else $error("halt not ended");
endmodule

bind dsfm_top dsfm_chk #(.L1NR_W(L1NR_W), .L1R_W(L1R_W), .L2_W(L2_W), .WARN_W(WARN_W))
  i_dsfm_chk (.*);

// ---- bench/dsfm_host.sv ----
// Host controller model that issues control words.
`timescale 1ns/1ps
module dsfm_host (
  input wire logic core_clk,
  output logic host_cw_valid,
  output logic [15:0] host_control_word
);
  initial begin
    host_cw_valid = 1'b0;
    host_control_word = 16'h0000;
  end
  task automatic send(input logic [15:0] w, input int gap);
    repeat (gap) @(negedge core_clk);
    @(negedge core_clk);
    host_cw_valid = 1'b1;
    host_control_word = w;
    @(negedge core_clk);
    host_cw_valid = 1'b0;
    host_control_word = ~w;
  endtask
  task automatic fault_reset();
    send(16'h0006, 0);
    send(16'h0086, 1);
  endtask
endmodule

// ---- bench/dsfm_top_tb.sv ----
// Self-checking bench for the drive state and fault manager.
`timescale 1ns/1ps
module dsfm_top_tb;
  logic core_clk = 1'b0, rst_n = 1'b0, self_check_done = 1'b0, param_wr_req = 1'b0;
  logic param_wr_run_ok = 1'b0, param_wr_is_frp = 1'b0, speed_ref_nz = 1'b0, stop_done = 1'b0;
  logic [15:0] param_wr_data = 16'h0000;
  logic [7:0] l1nr_src = 8'h00;
  logic [3:0] l1r_src = 4'h0, l2_src = 4'h0, warn_src = 4'h0;
  logic host_cw_valid, param_wr_ack_r, param_wr_nak_r, motor_energize_r, motor_move_r;
  logic stop_active_r, func_inhibit_r, servo_on_r, reset_done_r;
  logic [15:0] host_control_word, fault_reset_param_r;
  logic [2:0] drive_state_r;
  logic [7:0] l1nr_latch_r;
  logic [3:0] l1r_latch_r, l2_latch_r, warn_disp_r;
  logic [1:0] fault_level_r;
  int failures = 0, num_checks = 0;
  dsfm_top i_dsfm_top (.*);
  dsfm_host i_dsfm_host (.*);
  always #2.5 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic ok, input logic frp, input logic [15:0] d, input logic [1:0] exp);
    @(negedge core_clk);
    {param_wr_req, param_wr_run_ok, param_wr_is_frp, param_wr_data} = {1'b1, ok, frp, d};
    @(negedge core_clk);
    chk({param_wr_ack_r, param_wr_nak_r}, exp);
    chk({reset_done_r, fault_reset_param_r}, (exp == 2'b10 && frp && d == 16'h0001) ? 32'h10001 : 32'h0);
    param_wr_req = 1'b0;
    param_wr_data = ~d;
  endtask
  task automatic run_up();
    i_dsfm_host.send(16'h0006, 0);
    chk(drive_state_r, 3'h2);
    i_dsfm_host.send(16'h0007, 1);
    chk(drive_state_r, 3'h3);
    i_dsfm_host.send(16'h000f, 0);
    chk({drive_state_r, servo_on_r, motor_energize_r}, 5'h13);
  endtask
  task automatic l2_fault();
    l2_src = 4'h1;
    tick(1);
    l2_src = 4'h0;
    tick(1);
    chk({l2_latch_r, fault_level_r, drive_state_r}, 9'h036);
  endtask
  initial begin
    #20000;
    failures++;
    summarize();
  end
  initial begin
    tick(10);
    rst_n = 1'b1;
    chk({drive_state_r, func_inhibit_r}, 4'h1);
    wr(1'b0, 1'b0, 16'h0005, 2'b01);
    self_check_done = 1'b1;
    tick(2);
    wr(1'b0, 1'b0, 16'h0005, 2'b10);
    i_dsfm_host.send(16'h000f, 0);
    chk(drive_state_r, 3'h1);
    run_up();
    tick(2);
    chk(motor_move_r, 1'b0);
    speed_ref_nz = 1'b1;
    tick(2);
    chk(motor_move_r, 1'b1);
    wr(1'b0, 1'b0, 16'h0005, 2'b01);
    wr(1'b1, 1'b0, 16'h0005, 2'b10);
    wr(1'b1, 1'b1, 16'h0001, 2'b01);
    i_dsfm_host.send(16'h0002, 0);
    tick(1);
    chk({drive_state_r, stop_active_r, motor_move_r, motor_energize_r}, 6'h2d);
    stop_done = 1'b1;
    tick(2);
    chk(drive_state_r, 3'h1);
    warn_src = 4'h2;
    tick(2);
    chk({warn_disp_r, fault_level_r}, 6'h0b);
    warn_src = 4'h0;
    tick(2);
    chk({warn_disp_r, fault_level_r}, 6'h00);
    warn_src = 4'h4;
    tick(2);
    wr(1'b0, 1'b1, 16'h0002, 2'b01);
    wr(1'b0, 1'b1, 16'h0001, 2'b10);
    tick(1);
    chk({warn_disp_r, fault_reset_param_r}, 20'h00000);
    warn_src = 4'h0;
    stop_done = 1'b0;
    run_up();
    i_dsfm_host.send(16'h0007, 0);
    chk({drive_state_r, servo_on_r}, 4'h6);
    i_dsfm_host.send(16'h0006, 0);
    chk(drive_state_r, 3'h2);
    i_dsfm_host.send(16'h0000, 0);
    chk(drive_state_r, 3'h1);
    run_up();
    l2_fault();
    stop_done = 1'b1;
    tick(2);
    chk({drive_state_r, func_inhibit_r}, 4'hf);
    wr(1'b0, 1'b0, 16'h0005, 2'b10);
    i_dsfm_host.send(16'h008f, 0);
    chk(reset_done_r, 1'b1);
    tick(1);
    chk(l2_latch_r, 4'h1);
    i_dsfm_host.fault_reset();
    chk(reset_done_r, 1'b1);
    tick(2);
    chk({l2_latch_r, drive_state_r}, 7'h01);
    l2_fault();
    tick(2);
    i_dsfm_host.send(16'h0086, 0);
    chk(reset_done_r, 1'b0);
    tick(1);
    chk(l2_latch_r, 4'h1);
    i_dsfm_host.fault_reset();
    tick(2);
    {l1nr_src, l1r_src, l2_src} = 16'h0112;
    tick(1);
    {l1nr_src, l1r_src, l2_src} = 16'h0000;
    tick(2);
    chk(fault_level_r, 2'h1);
    i_dsfm_host.fault_reset();
    tick(2);
    chk({l1nr_latch_r, l1r_latch_r, l2_latch_r}, 16'h0100);
    chk({drive_state_r, fault_level_r}, 5'h1d);
    rst_n = 1'b0;
    tick(1);
    chk({l1nr_latch_r, drive_state_r}, 11'h000);
    rst_n = 1'b1;
    tick(2);
    chk(drive_state_r, 3'h1);
    summarize();
  end
endmodule
